// [common/cdr_ctrl_pkg.sv]
/*
 Constants shared by the serial control slave, its bus controller and the bench.
 Assumes a 100 MHz system clock on both ends.
*/
`default_nettype none
package cdr_ctrl_pkg;
   // ==================================================
   // Device register map
   localparam logic [7:0] RATE_LOW_OFS = 8'h00;
   localparam logic [7:0] RATE_MID_OFS = 8'h01;
   localparam logic [7:0] RATE_HIGH_OFS = 8'h02;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] LOCK_SRC_OFS = 8'h08;
   localparam logic [7:0] FLAG_RST_OFS = 8'h09;
   localparam logic [7:0] OUT_CFG_OFS = 8'h11;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int RATE_W = 23;
   // ==================================================
   // Device field positions
   localparam int STAT_LOS_BIT = 5;
   localparam int STAT_STICKY_BIT = 4;
   localparam int STAT_LOL_BIT = 3;
   localparam int STAT_DONE_BIT = 2;
   localparam int LS_LOCK_REF_BIT = 0;
   localparam int LS_MEASURE_BIT = 1;
   localparam int LS_RATIO_LSB = 2;
   localparam int LS_RANGE_LSB = 6;
   localparam int FR_CFG_LOL_BIT = 7;
   localparam int FR_CLR_LOL_BIT = 6;
   localparam int FR_SYSRST_BIT = 5;
   localparam int FR_CLR_DONE_BIT = 3;
   localparam int OC_LOS_POL_BIT = 2;
   localparam int OC_SQ_MODE_BIT = 1;
   localparam int ADDR_STRAP_BIT = 5;
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h40;
   // ==================================================
   // Bus controller registers (Wishbone byte addresses)
   localparam logic [7:0] HOST_CMD_OFS = 8'h00;
   localparam logic [7:0] HOST_STAT_OFS = 8'h04;
   localparam int CMD_DEV_LSB = 0;
   localparam int CMD_SUB_LSB = 8;
   localparam int CMD_WDATA_LSB = 16;
   localparam int CMD_READ_BIT = 24;
   localparam int CMD_GO_BIT = 31;
   localparam int HST_BUSY_BIT = 0;
   localparam int HST_NACK_BIT = 1;
   localparam int HST_RDATA_LSB = 8;
   // ==================================================
   // Link timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int SCL_QUARTER_NS = 650;
   localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : cdr_ctrl_pkg
`default_nettype wire

// [common/serial_ctrl_if.sv]
/*
 Two-wire serial management link between the bus controller and the device.
 Assumes SDA is open drain with a pull-up; SCL is driven by the controller only.
*/
`default_nettype none
interface serial_ctrl_if;
   logic scl;
   logic m_sda_oe;
   logic s_sda_oe;
   logic sda;
   // Wired-AND of both open-drain drivers, pulled high when nobody drives
   assign sda = !(m_sda_oe || s_sda_oe);
   modport master (output scl, output m_sda_oe, input sda);
   modport device (input scl, input sda, output s_sda_oe);
endinterface : serial_ctrl_if
`default_nettype wire

// [core/cdc_sync2.sv]
/*
 Two-flop synchroniser for a group of independent level inputs.
 Assumes each bit may change at any time relative to clk_sys.
*/
`default_nettype none
module cdc_sync2 #(parameter int W = 1) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   // ==================================================
   // Only the second stage is visible outside
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         meta_q <= '0;
         q <= '0;
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : cdc_sync2
`default_nettype wire

// [core/cdr_serial_slave.sv]
/*
 Serial management slave and register set of the clock recovery receiver.
 Assumes the link, strap and analogue status inputs are asynchronous to clk_sys,
 and that the rate measurement result arrives in the clk_sys domain.
*/
`default_nettype none
module cdr_serial_slave #(
   parameter logic [6:0] DEV_ADDR = cdr_ctrl_pkg::DEV_ADDR_DEFAULT
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Serial management link
   serial_ctrl_if.device link,
   // Straps and analogue status (asynchronous)
   input wire logic addr_bit_strap,
   input wire logic signal_absent_in,
   input wire logic loop_acquiring_in,
   input wire logic squelch_in,
   // Rate measurement result (clk_sys domain)
   input wire logic rate_done_in,
   input wire logic [cdr_ctrl_pkg::RATE_W-1:0] rate_value_in,
   // Loop controls
   output logic rate_measure_start,
   output logic lock_to_reference,
   output logic [1:0] reference_range,
   output logic [3:0] scaled_reference,
   output logic system_reset_pulse,
   // Status pins and output mutes
   output logic signal_absent_flag,
   output logic unlocked_flag,
   output logic squelch_data,
   output logic squelch_clock
);
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK,
      ST_WDATA, ST_WACK, ST_RDATA, ST_RACK, ST_RNEXT
   } slave_state_e;

   slave_state_e st_q;
   logic [5:0] sync_s;
   logic scl_s, sda_s, strap_s, los_s, acq_s, sq_s;
   logic scl_prev_q, sda_prev_q;
   logic scl_rise, scl_fall, start_det, stop_det;
   logic [3:0] cnt_q;
   logic [7:0] sh_q, tx_q, ptr_q, rd_byte, status;
   logic rw_q, oe_q;
   logic wr_stb_q;
   logic [7:0] wr_addr_q, wr_data_q;
   logic [6:0] own_addr;
   logic [7:0] lock_src_q, flag_rst_q, out_cfg_q;
   logic sticky_q, done_q;
   logic [cdr_ctrl_pkg::RATE_W-1:0] rate_q;
   logic soft_rst, clr_sticky, clr_done, meas_go, wr_flag;

   // ==================================================
   // Input synchronisation and link events
   cdc_sync2 #(.W(6)) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .d({link.scl, link.sda, addr_bit_strap, signal_absent_in, loop_acquiring_in, squelch_in}),
      .q(sync_s)
   );
   assign {scl_s, sda_s, strap_s, los_s, acq_s, sq_s} = sync_s;

   // Previous levels for edge and start/stop detection
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end
      else
      begin
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
      end
   end

   assign scl_rise = scl_s && !scl_prev_q;
   assign scl_fall = !scl_s && scl_prev_q;
   assign start_det = scl_s && scl_prev_q && sda_prev_q && !sda_s;
   assign stop_det = scl_s && scl_prev_q && !sda_prev_q && sda_s;
   assign link.s_sda_oe = oe_q;

   // Strap replaces one bit of the base address, so two parts can share the bus
   always_comb
   begin
      own_addr = DEV_ADDR;
      own_addr[cdr_ctrl_pkg::ADDR_STRAP_BIT] = strap_s;
   end

   // ==================================================
   // Read multiplexer; reads change no state except advancing the register pointer
   always_comb
   begin
      status = 8'h00;
      status[cdr_ctrl_pkg::STAT_LOS_BIT] = los_s;
      status[cdr_ctrl_pkg::STAT_STICKY_BIT] = sticky_q;
      status[cdr_ctrl_pkg::STAT_LOL_BIT] = acq_s;
      status[cdr_ctrl_pkg::STAT_DONE_BIT] = done_q;
      case (ptr_q)
         cdr_ctrl_pkg::RATE_LOW_OFS: rd_byte = rate_q[7:0];
         cdr_ctrl_pkg::RATE_MID_OFS: rd_byte = rate_q[15:8];
         cdr_ctrl_pkg::RATE_HIGH_OFS: rd_byte = {1'b0, rate_q[22:16]};
         cdr_ctrl_pkg::STATUS_OFS: rd_byte = status;
         default: rd_byte = 8'h00; // Write-only and unmapped read as zero
      endcase
   end

   // ==================================================
   // Byte-level protocol engine: sample on SCL rise, drive on SCL fall
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         st_q <= ST_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         tx_q <= 8'h00;
         ptr_q <= 8'h00;
         rw_q <= 1'b0;
         oe_q <= 1'b0;
         wr_stb_q <= 1'b0;
         wr_addr_q <= 8'h00;
         wr_data_q <= 8'h00;
      end
      else
      begin
         wr_stb_q <= 1'b0;
         if (start_det)
         begin
            st_q <= ST_ADDR;
            cnt_q <= 4'h0;
            oe_q <= 1'b0;
         end
         else if (stop_det)
         begin
            st_q <= ST_IDLE;
            oe_q <= 1'b0;
         end
         else if (scl_rise)
         begin
            unique case (st_q)
               ST_ADDR, ST_SUB, ST_WDATA:
               begin
                  sh_q <= {sh_q[6:0], sda_s};
                  cnt_q <= cnt_q + 4'h1;
               end
               ST_RDATA: cnt_q <= cnt_q + 4'h1;
               ST_RACK: st_q <= sda_s ? ST_IDLE : ST_RNEXT;
               default: ;
            endcase
         end
         else if (scl_fall)
         begin
            unique case (st_q)
               ST_ADDR:
                  if (cnt_q == 4'h8)
                  begin
                     if (sh_q[7:1] == own_addr)
                     begin
                        oe_q <= 1'b1;
                        rw_q <= sh_q[0];
                        st_q <= ST_ADDR_ACK;
                     end
                     else
                        st_q <= ST_IDLE;
                  end
               ST_SUB:
                  if (cnt_q == 4'h8)
                  begin
                     ptr_q <= sh_q;
                     oe_q <= 1'b1;
                     st_q <= ST_SUB_ACK;
                  end
               ST_WDATA:
                  if (cnt_q == 4'h8)
                  begin
                     wr_stb_q <= 1'b1;
                     wr_addr_q <= ptr_q;
                     wr_data_q <= sh_q;
                     ptr_q <= ptr_q + 8'h01;
                     oe_q <= 1'b1;
                     st_q <= ST_WACK;
                  end
               ST_ADDR_ACK, ST_RNEXT:
               begin
                  cnt_q <= 4'h0;
                  if (rw_q)
                  begin
                     tx_q <= rd_byte;
                     oe_q <= !rd_byte[7];
                     ptr_q <= ptr_q + 8'h01;
                     st_q <= ST_RDATA;
                  end
                  else
                  begin
                     oe_q <= 1'b0;
                     st_q <= ST_SUB;
                  end
               end
               ST_SUB_ACK, ST_WACK:
               begin
                  oe_q <= 1'b0;
                  cnt_q <= 4'h0;
                  st_q <= ST_WDATA;
               end
               ST_RDATA:
                  if (cnt_q == 4'h8)
                  begin
                     oe_q <= 1'b0; // Release for the master's acknowledge
                     st_q <= ST_RACK;
                  end
                  else
                  begin
                     tx_q <= {tx_q[6:0], 1'b0};
                     oe_q <= !tx_q[6];
                  end
               default: ;
            endcase
         end
      end
   end

   // ==================================================
   // Write decode; clear and reset actions fire on a 1-to-0 write of their bit
   assign wr_flag = wr_stb_q && (wr_addr_q == cdr_ctrl_pkg::FLAG_RST_OFS);
   assign soft_rst = wr_flag && flag_rst_q[cdr_ctrl_pkg::FR_SYSRST_BIT]
                     && !wr_data_q[cdr_ctrl_pkg::FR_SYSRST_BIT];
   assign clr_sticky = wr_flag && flag_rst_q[cdr_ctrl_pkg::FR_CLR_LOL_BIT]
                       && !wr_data_q[cdr_ctrl_pkg::FR_CLR_LOL_BIT];
   assign clr_done = wr_flag && flag_rst_q[cdr_ctrl_pkg::FR_CLR_DONE_BIT]
                     && !wr_data_q[cdr_ctrl_pkg::FR_CLR_DONE_BIT];
   assign meas_go = wr_stb_q && (wr_addr_q == cdr_ctrl_pkg::LOCK_SRC_OFS)
                    && wr_data_q[cdr_ctrl_pkg::LS_MEASURE_BIT];

   // Control registers; reserved bits are stored but steer nothing
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || soft_rst)
      begin
         lock_src_q <= cdr_ctrl_pkg::CTRL_RESET;
         flag_rst_q <= cdr_ctrl_pkg::CTRL_RESET;
         out_cfg_q <= cdr_ctrl_pkg::CTRL_RESET;
      end
      else if (wr_stb_q)
      begin
         case (wr_addr_q)
            cdr_ctrl_pkg::LOCK_SRC_OFS: lock_src_q <= wr_data_q;
            cdr_ctrl_pkg::FLAG_RST_OFS: flag_rst_q <= wr_data_q;
            cdr_ctrl_pkg::OUT_CFG_OFS: out_cfg_q <= wr_data_q;
            default: ;
         endcase
      end
   end

   // Sticky flags and captured rate; a set in the clear cycle wins
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         sticky_q <= 1'b0;
         done_q <= 1'b0;
         rate_q <= '0;
      end
      else
      begin
         sticky_q <= acq_s || (sticky_q && !clr_sticky && !soft_rst);
         done_q <= rate_done_in || (done_q && !clr_done && !meas_go && !soft_rst);
         if (rate_done_in)
            rate_q <= rate_value_in;
      end
   end

   // ==================================================
   // Registered pin and control outputs
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         rate_measure_start <= 1'b0;
         system_reset_pulse <= 1'b0;
         lock_to_reference <= 1'b0;
         reference_range <= 2'h0;
         scaled_reference <= 4'h0;
         signal_absent_flag <= 1'b0;
         unlocked_flag <= 1'b0;
         squelch_data <= 1'b0;
         squelch_clock <= 1'b0;
      end
      else
      begin
         rate_measure_start <= meas_go;
         system_reset_pulse <= soft_rst;
         lock_to_reference <= lock_src_q[cdr_ctrl_pkg::LS_LOCK_REF_BIT];
         reference_range <= lock_src_q[cdr_ctrl_pkg::LS_RANGE_LSB +: 2];
         scaled_reference <= lock_src_q[cdr_ctrl_pkg::LS_RATIO_LSB +: 4];
         signal_absent_flag <= los_s ^ out_cfg_q[cdr_ctrl_pkg::OC_LOS_POL_BIT];
         unlocked_flag <= flag_rst_q[cdr_ctrl_pkg::FR_CFG_LOL_BIT] ? sticky_q : acq_s;
         squelch_data <= sq_s;
         squelch_clock <= sq_s && !out_cfg_q[cdr_ctrl_pkg::OC_SQ_MODE_BIT];
      end
   end
endmodule : cdr_serial_slave
`default_nettype wire

// [core/serial_ctrl_master.sv]
/*
 Two-wire bus controller that runs one register write or read per command.
 Assumes a classic Wishbone master issues commands and polls status.
*/
`default_nettype none
module serial_ctrl_master (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Serial management link
   serial_ctrl_if.master link,
   // Wishbone slave
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [7:0] wb_adr,
   input wire logic [3:0] wb_sel,
   input wire logic [31:0] wb_dat_w,
   output logic [31:0] wb_dat_r,
   output logic wb_ack
);
   typedef enum logic [3:0] {
      MS_IDLE, MS_START, MS_ADDRW, MS_SUB, MS_DATA,
      MS_RSTART, MS_ADDRR, MS_RECV, MS_STOP
   } mstep_e;

   mstep_e step_q;
   logic [31:0] cmd_q, stat;
   logic [6:0] qcnt_q;
   logic tick;
   logic [1:0] ph_q;
   logic [3:0] bit_q;
   logic scl_q, oe_q, nack_q, busy_q, sda_s, wr_fire, bit_val, is_byte;
   logic [7:0] rx_q, cur_byte;
   logic [6:0] dev;

   // ==================================================
   // Link pins; the returning data line crosses into clk_sys
   cdc_sync2 #(.W(1)) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .d(link.sda),
      .q(sda_s)
   );
   assign link.scl = scl_q;
   assign link.m_sda_oe = oe_q;

   // ==================================================
   // Wishbone: answer one cycle after the request, act on the ack edge
   assign wr_fire = wb_cyc && wb_stb && wb_we && wb_ack && (wb_adr == cdr_ctrl_pkg::HOST_CMD_OFS);
   always_comb
   begin
      stat = 32'h0000_0000;
      stat[cdr_ctrl_pkg::HST_BUSY_BIT] = busy_q;
      stat[cdr_ctrl_pkg::HST_NACK_BIT] = nack_q;
      stat[cdr_ctrl_pkg::HST_RDATA_LSB +: 8] = rx_q;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         wb_ack <= 1'b0;
         wb_dat_r <= 32'h0000_0000;
      end
      else
      begin
         wb_ack <= wb_cyc && wb_stb && !wb_ack;
         if (wb_adr == cdr_ctrl_pkg::HOST_CMD_OFS)
            wb_dat_r <= cmd_q;
         else if (wb_adr == cdr_ctrl_pkg::HOST_STAT_OFS)
            wb_dat_r <= stat;
         else
            wb_dat_r <= 32'h0000_0000;
      end
   end

   // Command register; writes while busy are dropped so a transfer is never torn
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         cmd_q <= 32'h0000_0000;
      else if (wr_fire && !busy_q)
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (wb_sel[i])
               cmd_q[i*8 +: 8] <= wb_dat_w[i*8 +: 8];
         end
         cmd_q[cdr_ctrl_pkg::CMD_GO_BIT] <= 1'b0;
      end
   end

   // ==================================================
   // Quarter-bit enable divider
   assign tick = busy_q && (qcnt_q == 7'(cdr_ctrl_pkg::SCL_QUARTER_CYC - 1));
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || !busy_q || tick)
         qcnt_q <= 7'h00;
      else
         qcnt_q <= qcnt_q + 7'h01;
   end

   // Byte to shift out in the current step
   assign dev = cmd_q[cdr_ctrl_pkg::CMD_DEV_LSB +: 7];
   always_comb
   begin
      unique case (step_q)
         MS_ADDRW: cur_byte = {dev, 1'b0};
         MS_SUB: cur_byte = cmd_q[cdr_ctrl_pkg::CMD_SUB_LSB +: 8];
         MS_DATA: cur_byte = cmd_q[cdr_ctrl_pkg::CMD_WDATA_LSB +: 8];
         MS_ADDRR: cur_byte = {dev, 1'b1};
         default: cur_byte = 8'hFF; // Released line while receiving
      endcase
   end
   assign is_byte = (step_q == MS_ADDRW) || (step_q == MS_SUB) || (step_q == MS_DATA)
                    || (step_q == MS_ADDRR) || (step_q == MS_RECV);
   assign bit_val = bit_q[3] ? 1'b1 : cur_byte[3'h7 - bit_q[2:0]];

   // ==================================================
   // Transfer sequencer: four quarter phases per bit
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         step_q <= MS_IDLE;
         busy_q <= 1'b0;
         nack_q <= 1'b0;
         ph_q <= 2'h0;
         bit_q <= 4'h0;
         scl_q <= 1'b1;
         oe_q <= 1'b0;
         rx_q <= 8'h00;
      end
      else if (!busy_q)
      begin
         if (wr_fire && wb_sel[3] && wb_dat_w[cdr_ctrl_pkg::CMD_GO_BIT])
         begin
            busy_q <= 1'b1;
            nack_q <= 1'b0;
            step_q <= MS_START;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
         end
      end
      else if (tick)
      begin
         ph_q <= ph_q + 2'h1;
         if (is_byte)
         begin
            unique case (ph_q)
               2'h0: oe_q <= !bit_val;
               2'h1: scl_q <= 1'b1;
               2'h2:
                  if (!bit_q[3])
                     rx_q <= {rx_q[6:0], sda_s};
                  else if (step_q != MS_RECV && sda_s)
                     nack_q <= 1'b1;
               2'h3:
               begin
                  scl_q <= 1'b0;
                  bit_q <= bit_q[3] ? 4'h0 : bit_q + 4'h1;
                  if (bit_q[3])
                  begin
                     unique case (step_q)
                        MS_ADDRW: step_q <= nack_q ? MS_STOP : MS_SUB;
                        MS_SUB:
                           if (nack_q)
                              step_q <= MS_STOP;
                           else
                              step_q <= cmd_q[cdr_ctrl_pkg::CMD_READ_BIT] ? MS_RSTART : MS_DATA;
                        MS_ADDRR: step_q <= nack_q ? MS_STOP : MS_RECV;
                        default: step_q <= MS_STOP;
                     endcase
                  end
               end
            endcase
         end
         else
         begin
            unique case (ph_q)
               2'h0: oe_q <= (step_q == MS_STOP);
               2'h1: scl_q <= 1'b1;
               2'h2: oe_q <= (step_q != MS_STOP); // Start falls, stop rises, with SCL high
               2'h3:
               begin
                  if (step_q == MS_STOP)
                  begin
                     busy_q <= 1'b0;
                     step_q <= MS_IDLE;
                  end
                  else
                  begin
                     scl_q <= 1'b0;
                     step_q <= (step_q == MS_START) ? MS_ADDRW : MS_ADDRR;
                  end
               end
            endcase
         end
      end
   end
endmodule : serial_ctrl_master
`default_nettype wire

// [sim/cdr_link_asserts.sv]
/*
 Wire checks for the two-wire link between controller and device.
 Assumes one clk_sys domain and the plain signals of the link interface.
*/
`default_nettype none
module cdr_link_asserts (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Link
   input wire logic scl,
   input wire logic m_sda_oe,
   input wire logic s_sda_oe,
   input wire logic sda
);
   // ==================================================
   // Link timing; the device may only move SDA while SCL is low
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Both ends may pull low together while SCL is low; only the high phase must be clean
   fight_free_a: assert property (scl && s_sda_oe |-> !m_sda_oe)
      else $error("sda fight");
   dev_low_a: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
      else $error("device moved sda");
   ack_delay_a: assert property ($rose(s_sda_oe) |-> $past(scl, 6) && !$past(scl, 2))
      else $error("device answer late");
   ack_hold_a: assert property ($rose(s_sda_oe) |-> s_sda_oe [*8]) else $error("short");
   scl_quarter_a: assert property ($changed(scl) |=> $stable(scl) [*8])
      else $error("scl glitch");
   low_phase_a: assert property ($fell(scl) |-> ##[100:160] $rose(scl))
      else $error("scl stuck low");
   start_master_a: assert property (scl && $fell(sda) |-> m_sda_oe) else $error("start");
   stop_master_a: assert property (scl && $rose(sda) |-> $past(m_sda_oe))
      else $error("stop");
   // Main scenarios reached
   cover property ($rose(s_sda_oe));
   cover property (scl && $fell(sda));
   cover property (scl && $rose(sda));
endmodule : cdr_link_asserts
`default_nettype wire

// [sim/cdr_serial_control_registers_tb_top.sv]
/*
 Bench joining the bus controller and the device over the link.
 Assumes package, interface and both ends are compiled first.
*/
`default_nettype none
module cdr_serial_control_registers_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [6:0] DA = cdr_ctrl_pkg::DEV_ADDR_DEFAULT | 7'h20;
   logic clk_sys, rst_n, wb_cyc, wb_stb, wb_we, wb_ack, rd_chk, seen_rst, seen_go;
   logic [3:0] wb_sel;
   logic [7:0] wb_adr, lsc;
   logic [31:0] wb_dat_w, wb_dat_r, dr, e;
   logic [31:0] exp_q[$];
   logic addr_bit_strap, signal_absent_in, loop_acquiring_in, squelch_in, rate_done_in;
   logic [22:0] rate_value_in;
   logic rate_measure_start, lock_to_reference, system_reset_pulse, signal_absent_flag;
   logic unlocked_flag, squelch_data, squelch_clock;
   logic [1:0] reference_range;
   logic [3:0] scaled_reference;
   int errors, checks, seed;
   serial_ctrl_if link ();
   serial_ctrl_master i_serial_ctrl_master (.*);
   cdr_serial_slave i_cdr_serial_slave (.*);
   cdr_link_asserts i_cdr_link_asserts (.clk_sys(clk_sys), .rst_n(rst_n), .scl(link.scl),
      .m_sda_oe(link.m_sda_oe), .s_sda_oe(link.s_sda_oe), .sda(link.sda));
   // ==================================================
   // Clock and watchdog; a hung link transfer must still end the run
   initial
   begin
      clk_sys = 1'h0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial
   begin
      #1200000;
      errors++;
      stop_test();
   end
   task automatic stop_test;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [15:0] g, input logic [15:0] x);
      checks++;
      if (g !== x)
      begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, g, x);
      end
   endtask : chk
   // Classic cycle: request held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      wb_cyc <= 1'h1;
      wb_stb <= 1'h1;
      wb_we <= w;
      wb_adr <= a;
      wb_dat_w <= d;
      do
         @(posedge clk_sys);
      while (wb_ack !== 1'h1);
      dr = wb_dat_r;
      wb_cyc <= 1'h0;
      wb_stb <= 1'h0;
      @(posedge clk_sys);
   endtask : wb
   // One link transfer, polled to completion, then status noted and checked
   task automatic op(input logic [6:0] dv, input logic [7:0] sub, input logic [7:0] d,
      input logic rd, input logic [31:0] x);
      int n;
      n = 0;
      wb(1'h1, cdr_ctrl_pkg::HOST_CMD_OFS, {1'h1, 6'h0, rd, d, sub, 1'h0, dv});
      do
      begin
         repeat (64) @(posedge clk_sys);
         wb(1'h0, cdr_ctrl_pkg::HOST_STAT_OFS, 32'h0);
         n++;
      end
      while (dr[0] !== 1'h0 && n < 300);
      // A transfer that never finishes counts against the run
      if (dr[0] !== 1'h0)
      begin
         errors++;
         $display("[ERR] %0t link transfer timed out", $time);
      end
      exp_q.push_back(x);
      rd_chk <= 1'h1;
      wb(1'h0, cdr_ctrl_pkg::HOST_STAT_OFS, 32'h0);
      rd_chk <= 1'h0;
   endtask : op
   // Monitor: upper half of a note masks the status, lower half is expected
   always @(posedge clk_sys)
   begin
      if (system_reset_pulse === 1'h1)
         seen_rst <= 1'h1;
      if (rate_measure_start === 1'h1)
         seen_go <= 1'h1;
      if (wb_ack === 1'h1 && rd_chk === 1'h1)
      begin
         e = exp_q.pop_front();
         chk(wb_dat_r[15:0] & e[31:16], e[15:0]);
      end
   end
   // ==================================================
   // Main sequence
   initial
   begin
      seed = 32'hEBC1;
      {rst_n, wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w, rd_chk, seen_rst, seen_go} = '0;
      {signal_absent_in, loop_acquiring_in, rate_done_in, rate_value_in} = '0;
      {wb_sel, addr_bit_strap, squelch_in} = 6'h3F;
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'h1;
      repeat (8) @(posedge clk_sys);
      chk({lock_to_reference, reference_range, scaled_reference, squelch_data, squelch_clock},
         16'h3);
      for (int i = 0; i < 4; i++)
      begin
         // Ratio 0101 suits every range, so a random lock source stays legal
         lsc = {i[1:0], 4'h5, 1'h1, 1'($random(seed))};
         op(DA, cdr_ctrl_pkg::LOCK_SRC_OFS, lsc, 1'h0, 32'h20000);
         chk({reference_range, scaled_reference, lock_to_reference}, {lsc[7:2], lsc[0]});
      end
      $display("control test done");
      signal_absent_in <= 1'h1;
      loop_acquiring_in <= 1'h1;
      repeat (10) @(posedge clk_sys);
      loop_acquiring_in <= 1'h0;
      repeat (10) @(posedge clk_sys);
      chk({seen_go, signal_absent_flag, unlocked_flag}, 16'h6);
      op(DA, cdr_ctrl_pkg::STATUS_OFS, 8'h0, 1'h1, 32'h3C023000);
      rate_value_in <= 23'($random(seed));
      rate_done_in <= 1'h1;
      @(posedge clk_sys);
      rate_done_in <= 1'h0;
      op(DA, cdr_ctrl_pkg::RATE_HIGH_OFS, 8'h0, 1'h1,
         {16'hFF02, 1'h0, rate_value_in[22:16], 8'h0});
      op(DA, cdr_ctrl_pkg::STATUS_OFS, 8'h0, 1'h1, 32'h04020400);
      $display("status test done");
      op(DA, cdr_ctrl_pkg::FLAG_RST_OFS, 8'hC8, 1'h0, 32'h20000);
      chk(unlocked_flag, 16'h1);
      op(DA, cdr_ctrl_pkg::FLAG_RST_OFS, 8'hA0, 1'h0, 32'h20000);
      chk(unlocked_flag, 16'h0);
      // Strap low moves the device to the base address; both flags now cleared
      addr_bit_strap <= 1'h0;
      op(cdr_ctrl_pkg::DEV_ADDR_DEFAULT, cdr_ctrl_pkg::STATUS_OFS, 8'h0, 1'h1,
         32'h3C022000);
      addr_bit_strap <= 1'h1;
      op(DA, cdr_ctrl_pkg::OUT_CFG_OFS, 8'h06, 1'h0, 32'h20000);
      chk({signal_absent_flag, squelch_data, squelch_clock}, 16'h2);
      op(DA, cdr_ctrl_pkg::FLAG_RST_OFS, 8'h00, 1'h0, 32'h20000);
      chk({seen_rst, lock_to_reference, reference_range, signal_absent_flag, squelch_clock},
         16'h23);
      $display("flag test done");
      op(cdr_ctrl_pkg::DEV_ADDR_DEFAULT, cdr_ctrl_pkg::STATUS_OFS, 8'h0, 1'h1, 32'h20002);
      $display("address test done");
      stop_test();
   end
endmodule : cdr_serial_control_registers_tb_top
`default_nettype wire
